//--- hdl/scn_pkg.sv
/*
 Constants shared by the scan order sequencer, its FIFO and its DAC expander.
 Assumes nothing of its surroundings.
*/
package scn_pkg;
   localparam int PIX_W = 24;
   localparam int COORD_W = 14;
   localparam int BLANK_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int DAC_W = 8;

   // Scan mode field
   localparam logic [1:0] SCAN_SINGLE = 2'h0;
   localparam logic [1:0] SCAN_DUAL = 2'h1;
   localparam logic [1:0] SCAN_ZIGZAG = 2'h2;

   // Bit stream format codes
   localparam logic [3:0] FMT_S1 = 4'h0;
   localparam logic [3:0] FMT_S2 = 4'h1;
   localparam logic [3:0] FMT_S4 = 4'h2;
   localparam logic [3:0] FMT_S6 = 4'h3;
   localparam logic [3:0] FMT_S8 = 4'h4;
   localparam logic [3:0] FMT_S9 = 4'h5;
   localparam logic [3:0] FMT_S12 = 4'h6;
   localparam logic [3:0] FMT_S18 = 4'h7;
   localparam logic [3:0] FMT_S24 = 4'h8;
   localparam logic [3:0] FMT_DAC_ONLY = 4'h9;

   // Bits per colour channel of the twin-capable digital formats
   localparam logic [3:0] CH_BITS_S9 = 4'h3;
   localparam logic [3:0] CH_BITS_S12 = 4'h4;
   localparam logic [3:0] CH_BITS_S18 = 4'h6;
   localparam logic [3:0] CH_BITS_S24 = 4'h8;

   // Reset values of the latched frame settings
   localparam logic [COORD_W-1:0] RST_COORD = 14'h0000;
   localparam logic [BLANK_W-1:0] RST_BLANK = 16'h0000;
endpackage : scn_pkg

//--- hdl/scn_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes a single clock and an asynchronous active high reset.
*/
`timescale 1ns/1ps
module scn_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;
   logic in_ready_reg;
   logic [AW:0] count_next;

   // Ready is registered so that the top level drives it straight from a flop
   assign o_in_ready = in_ready_reg;
   assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
   assign o_out_valid = (count_reg != '0);
   assign o_out_data = mem[rd_ptr_reg];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem[wr_ptr_reg] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         in_ready_reg <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_next;
         in_ready_reg <= (count_next != (AW+1)'(DEPTH));
      end
   end
endmodule : scn_fifo

//--- hdl/scn_dac_expand.sv
/*
 Extracts one colour channel from a packed RGB word and widens it to the
 DAC width by repeating its bits. Purely combinational; the caller registers.
*/
`timescale 1ns/1ps
module scn_dac_expand #(
   parameter int CH = 0
) (
   input wire logic [scn_pkg::PIX_W-1:0] i_word,
   input wire logic [3:0] i_bits,
   output logic [scn_pkg::DAC_W-1:0] o_chan
);
   logic [scn_pkg::PIX_W-1:0] field;

   always_comb
   begin
      field = i_word >> (CH * int'(i_bits));
      case (i_bits)
         scn_pkg::CH_BITS_S9: o_chan = {field[2:0], field[2:0], field[2:1]};
         scn_pkg::CH_BITS_S12: o_chan = {field[3:0], field[3:0]};
         scn_pkg::CH_BITS_S18: o_chan = {field[5:0], field[5:4]};
         default: o_chan = field[7:0];
      endcase
   end
endmodule : scn_dac_expand

//--- hdl/scn_order_twin.sv
/*
 Scan order sequencer with twin display output. Pulls scan dots from a
 FIFO fed by the pixel pipeline and emits them in single, dual or zigzag
 order, one dot per display clock cycle, on a digital lane pair and DACs.
 Assumes I_DOT_CLK is asynchronous and slower than a quarter of I_SYS_CLK,
 and that the frame settings are held steady while a frame runs.
 // Contract
 // [RL1] Twin mode drives digital pins and DACs together as primary plus secondary.
 // [RL2] Twin streams share one resolution and one timing.
 // [RL3] DAC-only format makes analog primary; 9 to 24 bit make digital primary.
 // [RL4] Analog secondary expands each channel to 8 bits by bit repetition.
 // [RL5] Digital outputs keep the width of the selected format.
 // [RL6] Single scan: one stream, left to right, line by line from top.
 // [RL7] Dual scan: two lanes at once, lower starting at the line offset.
 // [RL8] Dual scan: each stream carries exactly offset lines.
 // [RL9] Zigzag: one stream alternating line k and line offset plus k.
 // [RL10] Horizontal positions count scan dots, one per display clock.
 // [RL11] Each line outputs dots 0 to width minus one, one per cycle.
 // [RL12] Single and dual may blank between lines.
 // [RL13] Zigzag: no blanking between a line and its offset partner.
 // [RL14] Zigzag: blanking only after the offset-biased line.
 // [RL15] Leading and trailing frame blanking are allowed.
 // [RL16] A 2-bit mode selects single, dual or zigzag.
 // [RL17] Dual line offset is 14 bits wide.
 // [RL18] Dual scan puts upper and lower dots on separate lanes in one cycle.
*/
`timescale 1ns/1ps
module scn_order_twin #(
   parameter int FIFO_DEPTH = scn_pkg::FIFO_DEPTH
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RST,
   input wire logic I_DOT_CLK,
   input wire logic [1:0] I_SCAN_MODE,
   input wire logic I_TWIN_EN,
   input wire logic [3:0] I_FORMAT,
   input wire logic [scn_pkg::COORD_W-1:0] I_DUAL_LINE_OFFSET,
   input wire logic [scn_pkg::COORD_W-1:0] I_LINE_WIDTH_DOTS,
   input wire logic [scn_pkg::COORD_W-1:0] I_DISPLAY_HEIGHT_LINES,
   input wire logic [scn_pkg::BLANK_W-1:0] I_LEAD_DOTS,
   input wire logic [scn_pkg::BLANK_W-1:0] I_HBLANK_DOTS,
   input wire logic [scn_pkg::BLANK_W-1:0] I_TRAIL_DOTS,
   input wire logic I_PIX_VALID,
   output logic O_PIX_READY,
   input wire logic [scn_pkg::PIX_W-1:0] I_PIX_UPPER,
   input wire logic [scn_pkg::PIX_W-1:0] I_PIX_LOWER,
   output logic O_DOT_STROBE,
   output logic O_ACTIVE,
   output logic [scn_pkg::COORD_W-1:0] O_DOT_X,
   output logic [scn_pkg::COORD_W-1:0] O_UP_Y,
   output logic [scn_pkg::COORD_W-1:0] O_LO_Y,
   output logic [scn_pkg::PIX_W-1:0] O_DIG_UPPER,
   output logic [scn_pkg::PIX_W-1:0] O_DIG_LOWER,
   output logic [scn_pkg::DAC_W-1:0] O_DAC_R,
   output logic [scn_pkg::DAC_W-1:0] O_DAC_G,
   output logic [scn_pkg::DAC_W-1:0] O_DAC_B,
   output logic O_TWIN_ACTIVE,
   output logic O_ANALOG_PRIMARY,
   output logic O_FRAME_END,
   output logic O_UNDERRUN
);
   localparam int CW = scn_pkg::COORD_W;
   localparam int PW = scn_pkg::PIX_W;
   localparam int BW = scn_pkg::BLANK_W;

   typedef enum logic [1:0] {ST_LEAD, ST_ACTIVE, ST_HBLANK, ST_TRAIL} scn_state_t;

   scn_state_t state_reg;
   logic dclk_s1_reg;
   logic dclk_s2_reg;
   logic dclk_s3_reg;
   logic tick;
   logic [CW-1:0] x_reg;
   logic [CW-1:0] k_reg;
   logic phase_reg;
   logic [BW-1:0] blank_cnt_reg;
   logic [1:0] mode_reg;
   logic [3:0] fmt_reg;
   logic twin_reg;
   logic [CW-1:0] offset_reg;
   logic [CW-1:0] width_reg;
   logic [CW-1:0] height_reg;
   logic [BW-1:0] hblank_reg;
   logic [BW-1:0] trail_reg;
   logic [BW-1:0] lead_reg;
   logic emit;
   logic line_end;
   logic last_line;
   logic zig_pair;
   logic [CW-1:0] up_y;
   logic [CW-1:0] lo_y;
   logic fifo_valid;
   logic [2*PW-1:0] fifo_data;
   logic [PW-1:0] word_up;
   logic [PW-1:0] word_lo;
   logic twin_digital;
   logic twin_ok;
   logic [3:0] ch_bits;
   logic [4:0] dig_width;
   logic [PW-1:0] dig_mask;
   logic [scn_pkg::DAC_W-1:0] exp_chan [3];

   // Display clock is sampled through three stages; the second and third feed the edge detector
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         dclk_s1_reg <= 1'b0;
         dclk_s2_reg <= 1'b0;
         dclk_s3_reg <= 1'b0;
      end
      else
      begin
         dclk_s1_reg <= I_DOT_CLK;
         dclk_s2_reg <= dclk_s1_reg;
         dclk_s3_reg <= dclk_s2_reg;
      end
   end

   assign tick = dclk_s2_reg & ~dclk_s3_reg; // [RL10]
   assign emit = tick && (state_reg == ST_ACTIVE);
   assign line_end = (x_reg == width_reg - 1'b1); // [RL11]
   assign zig_pair = (mode_reg == scn_pkg::SCAN_ZIGZAG) && !phase_reg;

   always_comb
   begin
      case (mode_reg) // [RL16]
         scn_pkg::SCAN_DUAL: last_line = (k_reg == offset_reg - 1'b1); // [RL8]
         scn_pkg::SCAN_ZIGZAG: last_line = (k_reg == offset_reg - 1'b1) && phase_reg;
         default: last_line = (k_reg == height_reg - 1'b1);
      endcase
   end

   // Zigzag lifts every second line by the offset; dual lower lane always
   assign up_y = (mode_reg == scn_pkg::SCAN_ZIGZAG && phase_reg) ? k_reg + offset_reg : k_reg; // [RL9]
   assign lo_y = (mode_reg == scn_pkg::SCAN_DUAL) ? k_reg + offset_reg : '0; // [RL7]

   // Settings are taken only between frames, so both twin paths share them
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         mode_reg <= scn_pkg::SCAN_SINGLE;
         fmt_reg <= scn_pkg::FMT_S1;
         twin_reg <= 1'b0;
         offset_reg <= scn_pkg::RST_COORD;
         width_reg <= scn_pkg::RST_COORD;
         height_reg <= scn_pkg::RST_COORD;
         lead_reg <= scn_pkg::RST_BLANK;
         hblank_reg <= scn_pkg::RST_BLANK;
         trail_reg <= scn_pkg::RST_BLANK;
      end
      else if (state_reg == ST_LEAD)
      begin
         mode_reg <= I_SCAN_MODE;
         fmt_reg <= I_FORMAT;
         twin_reg <= I_TWIN_EN;
         offset_reg <= I_DUAL_LINE_OFFSET; // [RL17]
         width_reg <= I_LINE_WIDTH_DOTS;
         height_reg <= I_DISPLAY_HEIGHT_LINES;
         lead_reg <= I_LEAD_DOTS;
         hblank_reg <= I_HBLANK_DOTS;
         trail_reg <= I_TRAIL_DOTS; // [RL2]
      end
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         state_reg <= ST_LEAD;
         x_reg <= '0;
         k_reg <= '0;
         phase_reg <= 1'b0;
         blank_cnt_reg <= '0;
      end
      else if (tick)
      begin
         case (state_reg)
            ST_LEAD:
            begin
               if (blank_cnt_reg >= lead_reg) // [RL15]
               begin
                  state_reg <= ST_ACTIVE;
                  x_reg <= '0;
                  k_reg <= '0;
                  phase_reg <= 1'b0;
               end
               else
               begin
                  blank_cnt_reg <= blank_cnt_reg + 1'b1;
               end
            end
            ST_ACTIVE:
            begin
               if (!line_end)
               begin
                  x_reg <= x_reg + 1'b1; // [RL6]
               end
               else if (zig_pair)
               begin
                  x_reg <= '0; // [RL13]
                  phase_reg <= 1'b1;
               end
               else
               begin
                  x_reg <= '0;
                  phase_reg <= 1'b0;
                  blank_cnt_reg <= 16'h0001;
                  if (last_line)
                  begin
                     state_reg <= ST_TRAIL; // [RL15]
                     blank_cnt_reg <= '0;
                  end
                  else
                  begin
                     k_reg <= k_reg + 1'b1;
                     if (hblank_reg != '0)
                     begin
                        state_reg <= ST_HBLANK; // [RL12] [RL14]
                     end
                  end
               end
            end
            ST_HBLANK:
            begin
               if (blank_cnt_reg >= hblank_reg)
               begin
                  state_reg <= ST_ACTIVE;
               end
               else
               begin
                  blank_cnt_reg <= blank_cnt_reg + 1'b1;
               end
            end
            ST_TRAIL:
            begin
               if (blank_cnt_reg >= trail_reg)
               begin
                  state_reg <= ST_LEAD;
                  blank_cnt_reg <= '0;
               end
               else
               begin
                  blank_cnt_reg <= blank_cnt_reg + 1'b1;
               end
            end
            default: state_reg <= ST_LEAD;
         endcase
      end
   end

   scn_fifo #(
      .WIDTH(2*PW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(I_SYS_CLK),
      .i_rst(I_RST),
      .i_in_valid(I_PIX_VALID),
      .o_in_ready(O_PIX_READY),
      .i_in_data({I_PIX_LOWER, I_PIX_UPPER}),
      .o_out_valid(fifo_valid),
      .i_out_ready(emit),
      .o_out_data(fifo_data)
   );

   // A dot with no data behind it goes out as zero rather than stalling the line
   assign word_up = fifo_valid ? fifo_data[PW-1:0] : '0;
   assign word_lo = fifo_valid ? fifo_data[2*PW-1:PW] : '0;

   always_comb
   begin
      case (fmt_reg)
         scn_pkg::FMT_S1: dig_width = 5'd1;
         scn_pkg::FMT_S2: dig_width = 5'd2;
         scn_pkg::FMT_S4: dig_width = 5'd4;
         scn_pkg::FMT_S6: dig_width = 5'd6;
         scn_pkg::FMT_S8: dig_width = 5'd8;
         scn_pkg::FMT_S9: dig_width = 5'd9;
         scn_pkg::FMT_S12: dig_width = 5'd12;
         scn_pkg::FMT_S18: dig_width = 5'd18;
         scn_pkg::FMT_S24: dig_width = 5'd24;
         default: dig_width = 5'd24;
      endcase
      case (fmt_reg)
         scn_pkg::FMT_S9: ch_bits = scn_pkg::CH_BITS_S9;
         scn_pkg::FMT_S12: ch_bits = scn_pkg::CH_BITS_S12;
         scn_pkg::FMT_S18: ch_bits = scn_pkg::CH_BITS_S18;
         default: ch_bits = scn_pkg::CH_BITS_S24;
      endcase
   end

   assign dig_mask = PW'((25'h1 << dig_width) - 25'h1); // [RL5]
   assign twin_digital = (fmt_reg >= scn_pkg::FMT_S9) && (fmt_reg <= scn_pkg::FMT_S24);
   assign twin_ok = twin_reg && (twin_digital || fmt_reg == scn_pkg::FMT_DAC_ONLY); // [RL3]

   generate
      for (genvar c = 0; c < 3; c++)
      begin : g_exp
         scn_dac_expand #(
            .CH(c)
         ) u_exp (
            .i_word(word_up),
            .i_bits(ch_bits),
            .o_chan(exp_chan[c])
         );
      end
   endgenerate

   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_DOT_STROBE <= 1'b0;
         O_ACTIVE <= 1'b0;
         O_DOT_X <= '0;
         O_UP_Y <= '0;
         O_LO_Y <= '0;
      end
      else
      begin
         O_DOT_STROBE <= emit;
         if (tick)
         begin
            O_ACTIVE <= emit;
            O_DOT_X <= emit ? x_reg : '0;
            O_UP_Y <= emit ? up_y : '0;
            O_LO_Y <= emit ? lo_y : '0; // [RL18]
         end
      end
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_DIG_UPPER <= '0;
         O_DIG_LOWER <= '0;
         O_DAC_R <= '0;
         O_DAC_G <= '0;
         O_DAC_B <= '0;
      end
      else if (tick)
      begin
         O_DIG_UPPER <= '0;
         O_DIG_LOWER <= '0;
         O_DAC_R <= '0;
         O_DAC_G <= '0;
         O_DAC_B <= '0;
         if (emit)
         begin
            if (fmt_reg != scn_pkg::FMT_DAC_ONLY || twin_ok)
            begin
               O_DIG_UPPER <= word_up & dig_mask; // [RL1] [RL5]
            end
            if (mode_reg == scn_pkg::SCAN_DUAL && fmt_reg != scn_pkg::FMT_DAC_ONLY)
            begin
               O_DIG_LOWER <= word_lo & dig_mask; // [RL18]
            end
            if (fmt_reg == scn_pkg::FMT_DAC_ONLY || twin_ok)
            begin
               O_DAC_R <= exp_chan[2]; // [RL4]
               O_DAC_G <= exp_chan[1];
               O_DAC_B <= exp_chan[0];
            end
         end
      end
   end

   // Underrun is sticky for the frame; a new underrun beats the frame-start clear
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_TWIN_ACTIVE <= 1'b0;
         O_ANALOG_PRIMARY <= 1'b0;
         O_FRAME_END <= 1'b0;
         O_UNDERRUN <= 1'b0;
      end
      else
      begin
         O_TWIN_ACTIVE <= twin_ok; // [RL3]
         O_ANALOG_PRIMARY <= (fmt_reg == scn_pkg::FMT_DAC_ONLY);
         O_FRAME_END <= emit && line_end && last_line;
         if (emit && !fifo_valid)
         begin
            O_UNDERRUN <= 1'b1;
         end
         else if (tick && state_reg == ST_LEAD && blank_cnt_reg == '0)
         begin
            O_UNDERRUN <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (I_RST);

   a_dot_advance: assert property (emit && !line_end |=> x_reg == $past(x_reg) + 1'b1) // [RL11]
      else $error("scan dot did not advance by one");
   a_zig_no_blank: assert property (emit && line_end && zig_pair |=> state_reg == ST_ACTIVE && phase_reg) // [RL13]
      else $error("zigzag pair broken by blanking");
   a_zig_blank_spot: assert property ($rose(state_reg == ST_HBLANK) |-> $past(!zig_pair && line_end)) // [RL14]
      else $error("blanking entered mid line or mid pair");
   a_dual_lanes: assert property (O_DOT_STROBE && mode_reg == scn_pkg::SCAN_DUAL |-> O_LO_Y == O_UP_Y + offset_reg) // [RL7]
      else $error("dual lanes not offset");
   a_zig_bias: assert property (emit && mode_reg == scn_pkg::SCAN_ZIGZAG && phase_reg |=> O_UP_Y == $past(k_reg) + offset_reg) // [RL9]
      else $error("zigzag line not biased");
   a_dual_count: assert property (O_FRAME_END && mode_reg == scn_pkg::SCAN_DUAL |-> $past(k_reg) == offset_reg - 1'b1) // [RL8]
      else $error("dual stream line count wrong");
   a_dig_width: assert property (O_DOT_STROBE ##1 fmt_reg == scn_pkg::FMT_S9 [*1] |-> O_DIG_UPPER[PW-1:9] == '0) // [RL5]
      else $error("digital lane wider than format");
   a_dac_expand: assert property (O_DOT_STROBE && twin_ok && fmt_reg == scn_pkg::FMT_S12 |-> O_DAC_R[3:0] == O_DAC_R[7:4]) // [RL4]
      else $error("DAC channel not repeated");
   a_twin_refuse: assert property (!twin_reg || fmt_reg < scn_pkg::FMT_S9 |=> !O_TWIN_ACTIVE) // [RL3]
      else $error("twin shown for unsupported format");
   a_frame_stop: assert property (O_FRAME_END |-> state_reg == ST_TRAIL ##1 !O_DOT_STROBE) // [RL15]
      else $error("active dots past frame end");
   a_strobe_pulse: assert property (O_DOT_STROBE |=> !O_DOT_STROBE [*2]) // [RL10]
      else $error("dot strobe longer than a pulse");
endmodule : scn_order_twin

//--- tb/scn_display_model.sv
/*
 Display side model: makes the free running display clock that the panel
 and the CRT path share. Assumes the bench watches the dot outputs itself.
*/
`timescale 1ns/1ps
module scn_display_model #(
   parameter int HALF_NS = 80
) (
   output logic o_dot_clk
);
   // Odd start offset keeps the dot clock unrelated in phase to I_SYS_CLK
   initial
   begin
      o_dot_clk = 1'b0;
      #37;
      forever #(HALF_NS) o_dot_clk = ~o_dot_clk;
   end
endmodule : scn_display_model

//--- tb/scn_tb.sv
/*
 Self-checking bench for the scan order sequencer: frames in every scan mode
 and format, expected dots queued by the driver and checked by a watcher.
 Assumes the display model supplies the dot clock.
*/
`timescale 1ns/1ps
module testbench;
   localparam int FW[10] = '{1, 2, 4, 6, 8, 9, 12, 18, 24, 24};
   typedef struct packed {
      logic [13:0] x;
      logic [13:0] uy;
      logic [13:0] ly;
      logic [23:0] du;
      logic [23:0] dl;
      logic [23:0] dac;
      logic twin;
      logic ap;
      logic cont;
   } scn_note_t;
   logic clk, rst, dot_clk, valid, ready, twin_en, strobe, active, twin_act, an_pri, frame_end, underrun;
   logic [1:0] mode;
   logic [3:0] fmt;
   logic [13:0] off, wid, hgt, dx, uy, ly;
   logic [15:0] lead, hbl, trl;
   logic [23:0] pu, pl, du, dl, msk;
   logic [7:0] dr, dg, db;
   integer err_count, checks, seed, gap, full_seen;
   scn_note_t q[$];

   scn_display_model disp_u (.o_dot_clk(dot_clk));

   scn_order_twin dut_u (
      .I_SYS_CLK(clk), .I_RST(rst), .I_DOT_CLK(dot_clk), .I_SCAN_MODE(mode), .I_TWIN_EN(twin_en),
      .I_FORMAT(fmt), .I_DUAL_LINE_OFFSET(off), .I_LINE_WIDTH_DOTS(wid), .I_DISPLAY_HEIGHT_LINES(hgt),
      .I_LEAD_DOTS(lead), .I_HBLANK_DOTS(hbl), .I_TRAIL_DOTS(trl), .I_PIX_VALID(valid),
      .O_PIX_READY(ready), .I_PIX_UPPER(pu), .I_PIX_LOWER(pl), .O_DOT_STROBE(strobe),
      .O_ACTIVE(active), .O_DOT_X(dx), .O_UP_Y(uy), .O_LO_Y(ly), .O_DIG_UPPER(du), .O_DIG_LOWER(dl),
      .O_DAC_R(dr), .O_DAC_G(dg), .O_DAC_B(db), .O_TWIN_ACTIVE(twin_act), .O_ANALOG_PRIMARY(an_pri),
      .O_FRAME_END(frame_end), .O_UNDERRUN(underrun)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic miss(input string s);
      $display("mismatch %0t %s", $time, s);
      err_count++;
   endtask : miss

   task print_verdict;
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   // Bit repetition of an n-bit channel up to the 8-bit DAC range
   function automatic logic [7:0] exp8(input logic [23:0] w, input int n, input int ch);
      logic [7:0] r;
      for (int j = 0; j < 8; j++)
         r[j] = w[ch * n + n - 1 - ((7 - j) % n)];
      return r;
   endfunction : exp8

   // Valid stays high between words so it is never assigned twice in one step
   task automatic push_word;
      int k;
      valid = 1'b1;
      for (k = 0; k < 3000 && ready !== 1'b1; k++)
      begin
         full_seen = 1;
         @(negedge clk);
      end
      if (ready !== 1'b1)
      begin
         miss("ready timeout");
         print_verdict();
      end
      @(negedge clk);
   endtask : push_word

   task automatic note(input int i, input int li, input int x);
      scn_note_t n;
      logic tw;
      int nb;
      tw = twin_en && i >= 5;
      nb = FW[i] / 3;
      n.x = 14'(x);
      n.uy = (mode == scn_pkg::SCAN_ZIGZAG) ? 14'((li % 2) ? off + li / 2 : li / 2) : 14'(li);
      n.ly = (mode == scn_pkg::SCAN_DUAL) ? 14'(off + li) : '0;
      n.du = (i == 9 && !tw) ? '0 : pu;
      n.dl = (mode != scn_pkg::SCAN_DUAL || (i == 9 && !tw)) ? '0 : pl;
      n.dac = (i == 9) ? pu : tw ? {exp8(pu, nb, 2), exp8(pu, nb, 1), exp8(pu, nb, 0)} : '0;
      n.twin = tw;
      n.ap = (i == 9);
      n.cont = x != 0 || (li != 0 && (hbl == 0 || (mode == scn_pkg::SCAN_ZIGZAG && li % 2 == 1)));
      q.push_back(n);
   endtask : note

   always @(negedge clk)
   begin
      scn_note_t n;
      if (rst !== 1'b0)
         gap = 0;
      else
      begin
         gap = gap + 1;
         // A dot slot is 16 clocks, so gap 20 means the last slot was blank
         if (gap == 20)
         begin
            checks++;
            if (active !== 1'b0) miss("active flag during blanking");
         end
         if (strobe === 1'b1)
         begin
            checks += 5;
            if (q.size() == 0)
               miss("dot with nothing expected");
            else
            begin
               n = q.pop_front();
               if ({dx, uy, ly} !== {n.x, n.uy, n.ly}) miss("dot position");
               if ({du, dl} !== {n.du, n.dl}) miss("digital data");
               if ({dr, dg, db} !== n.dac) miss("dac data");
               if ({twin_act, an_pri, active} !== {n.twin, n.ap, 1'b1}) miss("twin flags");
               if ((gap < 24) !== n.cont) miss("blanking placement");
            end
            gap = 0;
         end
         if (frame_end === 1'b1 && q.size() != 0) miss("frame ended early");
      end
   end

   initial
   begin
      int nl;
      int k;
      seed = 32'h4ac9;
      err_count = 0;
      checks = 0;
      full_seen = 0;
      gap = 0;
      rst = 1'b1;
      valid = 1'b0;
      mode = 2'h0;
      fmt = 4'h6;
      twin_en = 1'b1;
      pu = '0;
      pl = '0;
      off = 14'h0002;
      wid = 14'h0005;
      hgt = 14'h0004;
      lead = 16'h0003;
      hbl = 16'h0002;
      trl = 16'h0001;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 10; i++)
      begin
         @(negedge clk);
         mode = (i == 9) ? 2'h3 : 2'(i % 3);
         fmt = 4'(i);
         twin_en = (i != 7);
         hbl = (i == 4) ? 16'h0000 : 16'h0002;
         nl = (mode == scn_pkg::SCAN_DUAL) ? off : (mode == scn_pkg::SCAN_ZIGZAG) ? 2 * off : hgt;
         msk = 24'((25'h1 << FW[i]) - 25'h1);
         for (int li = 0; li < nl; li++)
            for (int x = 0; x < wid; x++)
            begin
               pu = 24'($random(seed)) & msk;
               pl = 24'($random(seed)) & msk;
               note(i, li, x);
               push_word();
            end
         valid = 1'b0;
         for (k = 0; k < 4000 && frame_end !== 1'b1; k++)
            @(negedge clk);
         if (frame_end !== 1'b1)
         begin
            miss("frame end timeout");
            print_verdict();
         end
      end
      checks += 2;
      if (underrun !== 1'b0) miss("underrun flagged");
      if (full_seen != 1) miss("fifo never refused");
      print_verdict();
   end
endmodule : testbench
